// ---- inc/smc_pkg.sv ----
package smc_pkg;
    // system clock rate in hertz
    localparam int CLK_HZ = 10_000_000;
    // register byte offsets
    localparam logic [7:0] A_STAT = 8'h00;
    localparam logic [7:0] A_DATA = 8'h04;
    localparam logic [7:0] A_CTRL = 8'h08;
    localparam logic [7:0] A_VEL = 8'h0c;
    localparam logic [7:0] A_ACC = 8'h10;
    localparam logic [7:0] A_GAIN = 8'h14;
    localparam logic [7:0] A_DINT = 8'h18;
    localparam logic [7:0] A_ERRTH = 8'h1c;
    localparam logic [7:0] A_APOS = 8'h20;
    localparam logic [7:0] A_INDEX = 8'h24;
    // status byte bit positions
    localparam int ST_DONE = 2;
    localparam int ST_INDEX = 3;
    localparam int ST_PERR = 5;
    localparam int ST_BRK = 6;
    // control register fields
    localparam int CT_VMODE = 2;
    localparam int CT_ARM = 3;
    localparam int CT_VNEG = 4;
    localparam int CT_MASK = 8;
    // breakpoint mask bit clear, five others set
    localparam logic [13:0] CTRL_RST = 14'h1f00;
    localparam logic [15:0] ERRTH_RST = 16'h7fff;
    // command codes on the command port
    localparam logic [7:0] CMD_GO = 8'h01;
    localparam logic [7:0] CMD_STOP = 8'h07;
    localparam logic [7:0] CMD_CLR_IRQ = 8'h1d;
    // offset-binary zero codes
    localparam logic [11:0] DAC12_ZERO = 12'h800;
    localparam logic [7:0] DAC8_ZERO = 8'h80;
    // sample interval of 2048 clocks
    localparam logic [10:0] SAMPLE_LAST = 11'h7ff;
    // reset recovery time and its cycle count
    localparam int INIT_US = 1000;
    localparam int INIT_CYC = int'((64'(INIT_US) * 64'(CLK_HZ)) / 64'd1_000_000);
    // axi response codes
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    // motor output formats
    typedef enum logic [1:0] {OM_DAC8, OM_DAC12, OM_PWM} smc_omode_t;
    // reset recovery sequence
    typedef enum logic [1:0] {IN_Z12, IN_Z8, IN_RUN} smc_init_t;
endpackage

// ---- logic/smc_core.sv ----
`timescale 1ns/1ps
module smc_core #(
    parameter int INIT_CYC = smc_pkg::INIT_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic idx_in,
    output logic [7:0] motor_out_lines,
    output logic host_irq_out
);
    // recovery phase boundaries
    localparam logic [23:0] INIT_MID = 24'(INIT_CYC / 2);
    localparam logic [23:0] INIT_LAST = 24'(INIT_CYC - 1);

    // whole state of the block
    typedef struct packed {
        logic awrdy; // bus handshakes
        logic wrdy;
        logic bval;
        logic arrdy;
        logic rval;
        logic [1:0] bresp;
        logic [1:0] rresp;
        logic [31:0] rd;
        logic aw_got; // write halves held
        logic w_got;
        logic [7:0] awa;
        logic [31:0] wd;
        logic [3:0] ws;
        smc_pkg::smc_init_t ist; // recovery phase
        logic [23:0] icnt;
        logic [10:0] scnt; // sample timer
        logic [7:0] dcnt; // derivative countdown
        logic [2:0] q1; // sync stage one
        logic [2:0] q2; // sync stage two
        logic [1:0] qp; // previous a/b
        logic [31:0] apos; // actual position
        logic [31:0] ipos; // index capture
        logic [31:0] tgt; // target position
        logic [31:0] vel; // commanded velocity
        logic [31:0] acc;
        logic [31:0] gains; // kd high, kp low
        logic [7:0] dint; // derivative interval - 1
        logic [15:0] errth;
        logic [13:0] ctrl;
        logic [31:0] dpos; // desired position
        logic [15:0] dfrac;
        logic [31:0] des_v; // desired velocity
        logic moving;
        logic moff; // motor off flag
        logic [6:1] flg; // sticky events
        logic [15:0] eprev;
        logic [15:0] dterm;
        logic [15:0] u; // filter output
        logic [7:0] lines;
        logic irq;
    } smc_st_t;

    // reset image
    localparam smc_st_t ST_RST = '{
        ist: smc_pkg::IN_Z12, ctrl: smc_pkg::CTRL_RST, errth: smc_pkg::ERRTH_RST,
        awrdy: 1'b1, wrdy: 1'b1, arrdy: 1'b1, default: '0};

    smc_st_t s, n;
    logic [7:0] stat; // status byte
    logic [6:1] fset, fclr;
    logic tick, stop, port_sel_n;
    logic [31:0] rem, mag, nv, vabs32;
    logic [63:0] pv, pa;
    logic [47:0] p48;
    logic signed [31:0] e32;
    logic [15:0] esat, prod, val, vabs;
    logic [11:0] c12;
    logic [7:0] c8;
    logic [5:0] w6;
    smc_pkg::smc_omode_t om;

    // byte-lane merge for writes
    function automatic logic [31:0] smc_wmerge(input logic [31:0] o,
        input logic [31:0] d, input logic [3:0] b);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (b[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // bit order swap, first line carries msb
    function automatic logic [7:0] smc_rev8(input logic [7:0] x);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = x[7-i];
        end
        return r;
    endfunction

    // step a velocity toward its limit by one acceleration
    function automatic logic [31:0] smc_ramp(input logic [31:0] v,
        input logic [31:0] vmax, input logic [31:0] a);
        if (v < vmax) begin
            return (vmax - v > a) ? v + a : vmax;
        end else if (v > vmax) begin
            return (v - vmax > a) ? v - a : vmax;
        end
        return v;
    endfunction

    assign stat = {s.moff, s.flg, 1'b0};

    // next-state logic
    always_comb begin
        n = s;
        fset = '0;
        fclr = '0;
        stop = 1'b0;
        nv = s.des_v;
        p48 = {s.dpos, s.dfrac};
        tick = (s.scnt == smc_pkg::SAMPLE_LAST);
        n.scnt = s.scnt + 11'h1;
        // two-flop sync; only stage two is looked at
        n.q1 = {idx_in, enc_b, enc_a};
        n.q2 = s.q1;
        n.qp = s.q2[1:0];
        // one count per edge of either phase, a leading a is up
        if (s.q2[1:0] != s.qp) begin
            if (s.qp[1] ^ s.q2[0]) begin
                n.apos = s.apos + 32'h1;
            end else begin
                n.apos = s.apos - 32'h1;
            end
        end
        // index capture fires once then disarms; keeps the count of the all-low state itself
        if (s.ctrl[smc_pkg::CT_ARM] && s.q2 == 3'h0) begin
            n.ipos = n.apos;
            n.ctrl[smc_pkg::CT_ARM] = 1'b0;
            fset[smc_pkg::ST_INDEX] = 1'b1;
        end
        // reset recovery: hold status 00 until done
        unique case (s.ist)
            smc_pkg::IN_Z12: begin
                n.icnt = s.icnt + 24'h1;
                if (s.icnt == INIT_MID) begin
                    n.ist = smc_pkg::IN_Z8;
                end
            end
            smc_pkg::IN_Z8: begin
                n.icnt = s.icnt + 24'h1;
                if (s.icnt == INIT_LAST) begin
                    n.ist = smc_pkg::IN_RUN;
                    n.moff = 1'b1;
                    fset[smc_pkg::ST_DONE] = 1'b1;
                end
            end
            smc_pkg::IN_RUN: begin
            end
            default: begin
                n.ist = smc_pkg::IN_Z12;
            end
        endcase
        // error term, saturated to 16 bits
        e32 = signed'(s.dpos - s.apos);
        if (e32 > 32'sd32767) begin
            esat = 16'h7fff;
        end else if (e32 < -32'sd32768) begin
            esat = 16'h8000;
        end else begin
            esat = e32[15:0];
        end
        vabs32 = e32[31] ? 32'(-e32) : 32'(e32);
        prod = s.gains[15:0] * esat;
        // position-mode braking test: v*v against 2*a*d
        rem = s.tgt - s.dpos;
        mag = rem[31] ? -rem : rem;
        pv = s.des_v * s.des_v;
        pa = s.acc * mag;
        if (tick && s.ist == smc_pkg::IN_RUN) begin
            n.u = prod + s.dterm;
            if (vabs32 > {16'h0, s.errth}) begin
                fset[smc_pkg::ST_PERR] = 1'b1;
            end
            // derivative refreshed every dint+1 samples
            if (s.dcnt == 8'h0) begin
                n.dcnt = s.dint;
                n.dterm = s.gains[31:16] * 16'(esat - s.eprev);
                n.eprev = esat;
            end else begin
                n.dcnt = s.dcnt - 8'h1;
            end
            if (s.moving && s.ctrl[smc_pkg::CT_VMODE]) begin
                // velocity mode never waits for the motor
                nv = smc_ramp(s.des_v, s.vel, s.acc);
                if (s.ctrl[smc_pkg::CT_VNEG]) begin
                    p48 = p48 - {16'h0, nv};
                end else begin
                    p48 = p48 + {16'h0, nv};
                end
            end else if (s.moving) begin
                stop = ({17'h0, pv} >= {pa, 17'h0});
                if (stop) begin
                    nv = (s.des_v > s.acc) ? s.des_v - s.acc : 32'h0;
                end else begin
                    nv = smc_ramp(s.des_v, s.vel, s.acc);
                end
                // arrival snaps exactly onto the target
                if (mag <= {16'h0, nv[31:16]}) begin
                    p48 = {s.tgt, 16'h0};
                    nv = 32'h0;
                    n.moving = 1'b0;
                    fset[smc_pkg::ST_DONE] = 1'b1;
                end else if (rem[31]) begin
                    p48 = p48 - {16'h0, nv};
                end else begin
                    p48 = p48 + {16'h0, nv};
                end
            end
            n.des_v = nv;
            n.dpos = p48[47:16];
            n.dfrac = p48[15:0];
        end
        // motor output formatter, refreshed every clock
        val = s.moff ? 16'h0 : s.u;
        vabs = val[15] ? 16'(-val) : val;
        c12 = val[15:4] ^ smc_pkg::DAC12_ZERO;
        c8 = val[15:8] ^ smc_pkg::DAC8_ZERO;
        unique case (smc_pkg::smc_omode_t'(s.ctrl[1:0]))
            smc_pkg::OM_DAC12: om = smc_pkg::OM_DAC12;
            smc_pkg::OM_PWM: om = smc_pkg::OM_PWM;
            default: om = smc_pkg::OM_DAC8;
        endcase
        if (s.ist == smc_pkg::IN_Z12) begin
            om = smc_pkg::OM_DAC12;
            c12 = smc_pkg::DAC12_ZERO;
        end else if (s.ist == smc_pkg::IN_Z8) begin
            om = smc_pkg::OM_DAC8;
            c8 = smc_pkg::DAC8_ZERO;
        end
        // 12-bit words cycle every 8 clocks, 2 clocks per phase
        w6 = s.scnt[2] ? c12[11:6] : c12[5:0];
        unique case (om)
            smc_pkg::OM_DAC12: begin
                n.lines = {s.scnt[1], s.scnt[2], 6'(smc_rev8({w6, 2'h0}))};
            end
            smc_pkg::OM_PWM: begin
                n.lines = {6'h0, (s.scnt[6:0] < vabs[15:9]), val[15]};
            end
            default: begin
                n.lines = smc_rev8(c8);
            end
        endcase
        // write channel: accept address and data in either order
        if (s.awrdy && s_axi_awvalid) begin
            n.aw_got = 1'b1;
            n.awa = s_axi_awaddr;
        end
        if (s.wrdy && s_axi_wvalid) begin
            n.w_got = 1'b1;
            n.wd = s_axi_wdata;
            n.ws = s_axi_wstrb;
        end
        if (s.bval && s_axi_bready) begin
            n.bval = 1'b0;
        end
        port_sel_n = (s.awa != smc_pkg::A_STAT);
        if (s.aw_got && s.w_got && !s.bval) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bval = 1'b1;
            n.bresp = smc_pkg::RESP_OK;
            if (!port_sel_n) begin
                // command port, low byte holds the code
                if (s.ws[0]) begin
                    unique case (s.wd[7:0])
                        smc_pkg::CMD_GO: begin
                            n.moving = 1'b1;
                            n.moff = 1'b0;
                        end
                        smc_pkg::CMD_STOP: begin
                            n.moving = 1'b0;
                            n.des_v = 32'h0;
                        end
                        smc_pkg::CMD_CLR_IRQ: begin
                            fclr = ~s.wd[13:8];
                        end
                        default: begin
                        end
                    endcase
                end
            end else begin
                case (s.awa)
                    smc_pkg::A_DATA: n.tgt = smc_wmerge(s.tgt, s.wd, s.ws);
                    smc_pkg::A_CTRL: n.ctrl = 14'(smc_wmerge({18'h0, s.ctrl}, s.wd, s.ws));
                    smc_pkg::A_VEL: n.vel = smc_wmerge(s.vel, s.wd, s.ws);
                    smc_pkg::A_ACC: n.acc = smc_wmerge(s.acc, s.wd, s.ws);
                    smc_pkg::A_GAIN: n.gains = smc_wmerge(s.gains, s.wd, s.ws);
                    smc_pkg::A_DINT: n.dint = 8'(smc_wmerge({24'h0, s.dint}, s.wd, s.ws));
                    smc_pkg::A_ERRTH: n.errth = 16'(smc_wmerge({16'h0, s.errth}, s.wd, s.ws));
                    default: n.bresp = smc_pkg::RESP_ERR;
                endcase
            end
        end
        n.awrdy = !n.aw_got && !n.bval;
        n.wrdy = !n.w_got && !n.bval;
        // read channel: one read at a time, answer next clock
        if (s.rval && s_axi_rready) begin
            n.rval = 1'b0;
            n.arrdy = 1'b1;
        end
        if (s.arrdy && s_axi_arvalid) begin
            n.arrdy = 1'b0;
            n.rval = 1'b1;
            n.rresp = smc_pkg::RESP_OK;
            case (s_axi_araddr)
                smc_pkg::A_STAT: n.rd = {24'h0, stat};
                smc_pkg::A_DATA: n.rd = s.apos;
                smc_pkg::A_CTRL: n.rd = {18'h0, s.ctrl};
                smc_pkg::A_VEL: n.rd = s.vel;
                smc_pkg::A_ACC: n.rd = s.acc;
                smc_pkg::A_GAIN: n.rd = s.gains;
                smc_pkg::A_DINT: n.rd = {24'h0, s.dint};
                smc_pkg::A_ERRTH: n.rd = {16'h0, s.errth};
                smc_pkg::A_APOS: n.rd = s.apos;
                smc_pkg::A_INDEX: n.rd = s.ipos;
                default: begin
                    n.rd = 32'h0;
                    n.rresp = smc_pkg::RESP_ERR;
                end
            endcase
        end
        // sticky flags: a set in the clearing clock survives
        n.flg = (s.flg & ~fclr) | fset;
        n.irq = |(n.flg & n.ctrl[13:8]);
    end

    // state register; reset image zeroes position and all parameters but ctrl and errth
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s <= ST_RST;
        end else begin
            s <= n;
        end
    end

    assign s_axi_awready = s.awrdy;
    assign s_axi_wready = s.wrdy;
    assign s_axi_bvalid = s.bval;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arrdy;
    assign s_axi_rvalid = s.rval;
    assign s_axi_rdata = s.rd;
    assign s_axi_rresp = s.rresp;
    assign motor_out_lines = s.lines;
    assign host_irq_out = s.irq;

    // checks on the design's own behaviour
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_irq_gate: assert property ((|(s.flg & s.ctrl[13:8])) |-> host_irq_out)
        else $error("irq not raised for enabled flag");
    a_stat_zero: assert property ((s.ist != smc_pkg::IN_RUN) |-> stat == 8'h00)
        else $error("status not 00 during recovery");
    a_init_done: assert property ((s.ist == smc_pkg::IN_RUN
        && $past(s.ist) == smc_pkg::IN_Z8) |-> stat[7] && stat[smc_pkg::ST_DONE])
        else $error("status not 84 after recovery");
    a_zero_eight: assert property ((s.ist == smc_pkg::IN_Z8
        && $past(s.ist) == smc_pkg::IN_Z8) |-> motor_out_lines == 8'h01)
        else $error("8-bit zero code missing");
    a_quad_up: assert property ((s.q2[1:0] != s.qp && (s.qp[1] ^ s.q2[0]))
        |=> s.apos == $past(s.apos) + 32'h1)
        else $error("forward edge not counted up");
    a_index_cap: assert property ((s.ctrl[smc_pkg::CT_ARM] && s.q2 == 3'h0)
        |=> s.ipos == s.apos && s.flg[smc_pkg::ST_INDEX])
        else $error("index capture missed");
    a_vel_adv: assert property ((tick && s.moving && s.ctrl[smc_pkg::CT_VMODE]
        && s.ist == smc_pkg::IN_RUN && s.des_v == s.vel && s.vel[31:16] != 16'h0)
        |=> s.dpos != $past(s.dpos))
        else $error("velocity mode stopped advancing");
    a_pwm_unused: assert property ((s.ist == smc_pkg::IN_RUN && s.ctrl[1:0] == 2'h2)
        |=> motor_out_lines[7:2] == 6'h0)
        else $error("pwm spare lines driven");
    a_strobe_hold: assert property (($past(s.ist, 2) == smc_pkg::IN_RUN
        && $past(s.ctrl[1:0], 2) == 2'h1 && $past(s.ctrl[1:0]) == 2'h1
        && $rose(motor_out_lines[7])) |-> $stable(motor_out_lines[6:0]))
        else $error("12-bit data moved at strobe");

    c_index: cover property (s.flg[smc_pkg::ST_INDEX] && !$past(s.flg[smc_pkg::ST_INDEX]));
    c_arrive: cover property (s.moving && !s.ctrl[smc_pkg::CT_VMODE] ##1 !s.moving);
    c_recover: cover property (s.ist == smc_pkg::IN_Z8 ##1 s.ist == smc_pkg::IN_RUN);
endmodule

// ---- test/servo_motion_controller_tb.sv ----
`timescale 1ns/1ps
module servo_motion_controller_tb;
    localparam int INIT = 40; // shortened recovery time
    logic mclk = 1'h0;
    logic rst_n = 1'h0;
    logic [7:0] aa = 8'h00, ra = 8'h00, lines;
    logic [31:0] wd = 32'h0, rdat, d;
    logic av = 1'h0, wv = 1'h0, br = 1'h0, rv = 1'h0, rr = 1'h0;
    logic ar, wr_ok, bv, arr, rval, irq, ea, eb, ix, erdy, step = 1'h0, up = 1'h1, ien = 1'h0;
    logic [1:0] bres, rres, r;
    int fail_count = 0, comparisons = 0, cyc = 0, exp_pos = 0, n;
    always #50 mclk = ~mclk;
    smc_core #(.INIT_CYC(INIT)) dut (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(aa),
        .s_axi_awvalid(av), .s_axi_awready(ar), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wr_ok), .s_axi_bresp(bres), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ra), .s_axi_arvalid(rv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rres), .s_axi_rvalid(rval), .s_axi_rready(rr),
        .enc_a(ea), .enc_b(eb), .idx_in(ix), .motor_out_lines(lines), .host_irq_out(irq));
    smc_enc_model enc (.mclk(mclk), .step(step), .dir_up(up), .idx_en(ien), .enc_a(ea),
        .enc_b(eb), .idx_in(ix), .ready(erdy));
    // verdict, reached from the main sequence or the watchdog
    task automatic test_done;
        if (fail_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // a hang counts as a mismatch
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // axi write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] res);
        logic at, dt;
        at = 1'h0;
        dt = 1'h0;
        @(posedge mclk);
        aa <= a;
        wd <= v;
        av <= 1'h1;
        wv <= 1'h1;
        br <= 1'h1;
        do begin
            @(posedge mclk);
            at = at | ar;
            dt = dt | wr_ok;
            av <= !at;
            wv <= !dt;
        end while (!(at && dt));
        do @(posedge mclk); while (bv !== 1'h1);
        res = bres;
        br <= 1'h0;
    endtask
    // axi read: rready held up until the data edge
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] res);
        @(posedge mclk);
        ra <= a;
        rv <= 1'h1;
        rr <= 1'h1;
        do @(posedge mclk); while (arr !== 1'h1);
        rv <= 1'h0;
        do @(posedge mclk); while (rval !== 1'h1);
        v = rdat;
        res = rres;
        rr <= 1'h0;
    endtask
    // encoder steps; the task tracks the expected count
    task automatic mv(input int k, input logic dir);
        repeat (k) begin
            @(posedge mclk);
            up <= dir;
            step <= 1'h1;
            @(posedge mclk);
            step <= 1'h0;
            do @(posedge mclk); while (erdy !== 1'h1);
            exp_pos = dir ? exp_pos + 1 : exp_pos - 1;
        end
    endtask
    // twelve-bit zero code: low word all zero, high word only its msb on line 0
    task automatic chk12;
        int rises;
        logic p;
        rises = 0;
        @(posedge mclk);
        p = lines[7];
        repeat (8) begin
            @(posedge mclk);
            chk("dac12 word", lines[6] ? 32'h1 : 32'h0, 32'(lines[5:0]));
            rises += (lines[7] && !p) ? 1 : 0;
            p = lines[7];
        end
        chk("dac12 strobe rises", 32'h2, 32'(rises));
    endtask
    initial begin
        logic [7:0] adr [9];
        logic [31:0] rvl [9];
        adr = '{smc_pkg::A_CTRL, smc_pkg::A_ERRTH, smc_pkg::A_DINT, smc_pkg::A_VEL,
            smc_pkg::A_ACC, smc_pkg::A_GAIN, smc_pkg::A_APOS, smc_pkg::A_INDEX, smc_pkg::A_DATA};
        rvl = '{32'h1f00, 32'h7fff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
        n = $urandom(53741);
        repeat (20) @(posedge mclk);
        rst_n <= 1'h1;
        // recovery: twelve-bit zero first, status still clear
        chk12();
        rd(smc_pkg::A_STAT, d, r);
        chk("status early", 32'h00, d);
        repeat (INIT) @(posedge mclk);
        rd(smc_pkg::A_STAT, d, r);
        chk("status ready", 32'h84, d);
        chk("dac8 zero", 32'h01, 32'(lines));
        chk("irq done", 32'h1, 32'(irq));
        for (int i = 0; i < 9; i++) begin
            rd(adr[i], d, r);
            chk("reset value", rvl[i], d);
        end
        wr(smc_pkg::A_STAT, 32'h1d, r);
        rd(smc_pkg::A_STAT, d, r);
        chk("status cleared", 32'h80, d);
        chk("irq cleared", 32'h0, 32'(irq));
        // unmapped place answers with an error both ways
        rd(8'h40, d, r);
        chk("unmapped rdata", 32'h0, d);
        chk("unmapped rresp", 32'(smc_pkg::RESP_ERR), 32'(r));
        wr(8'h40, 32'h5a, r);
        chk("unmapped bresp", 32'(smc_pkg::RESP_ERR), 32'(r));
        // output formats with the motor off
        wr(smc_pkg::A_CTRL, 32'h1f01, r);
        chk12();
        wr(smc_pkg::A_CTRL, 32'h1f02, r);
        repeat (3) @(posedge mclk);
        chk("pwm lines", 32'h0, 32'(lines));
        wr(smc_pkg::A_CTRL, 32'h1f03, r);
        repeat (3) @(posedge mclk);
        chk("dac8 lines", 32'h01, 32'(lines));
        // random travel up, then a shorter way back
        mv($urandom_range(20, 5), 1'h1);
        mv($urandom_range(4, 0), 1'h0);
        rd(smc_pkg::A_APOS, d, r);
        chk("actual position", 32'(exp_pos), d);
        rd(smc_pkg::A_DATA, d, r);
        chk("data port position", 32'(exp_pos), d);
        // index capture: leave the all-low state, arm, then come back to it
        if (exp_pos % 4 == 0) mv(1, 1'h1);
        ien <= 1'h1;
        wr(smc_pkg::A_CTRL, 32'h1f08, r);
        mv(4 - exp_pos % 4, 1'h1);
        n = exp_pos;
        rd(smc_pkg::A_INDEX, d, r);
        chk("index position", 32'(n), d);
        rd(smc_pkg::A_STAT, d, r);
        chk("status index", 32'h88, d);
        chk("irq index", 32'h1, 32'(irq));
        rd(smc_pkg::A_CTRL, d, r);
        chk("arm self clear", 32'h1f00, d);
        mv(4, 1'h1);
        rd(smc_pkg::A_INDEX, d, r);
        chk("index held", 32'(n), d);
        // short move: one count per sample reaches a target two counts away in two samples
        wr(smc_pkg::A_STAT, 32'h1d, r);
        wr(smc_pkg::A_VEL, 32'h10000, r);
        wr(smc_pkg::A_ACC, 32'h10000, r);
        wr(smc_pkg::A_DATA, 32'h2, r);
        wr(smc_pkg::A_STAT, 32'h01, r);
        repeat (4200) @(posedge mclk);
        rd(smc_pkg::A_STAT, d, r);
        chk("status arrived", 32'h04, d);
        chk("irq arrived", 32'h1, 32'(irq));
        // stalled motor in velocity mode: the error grows past a tight threshold
        wr(smc_pkg::A_ERRTH, 32'(exp_pos - 1), r);
        wr(smc_pkg::A_CTRL, 32'h1f14, r);
        wr(smc_pkg::A_STAT, 32'h01, r);
        repeat (6200) @(posedge mclk);
        rd(smc_pkg::A_STAT, d, r);
        chk("status position error", 32'h24, d);
        test_done();
    end
endmodule

// ---- test/smc_enc_model.sv ----
`timescale 1ns/1ps
// quadrature encoder with optional index, one state step per request
module smc_enc_model (
    input wire logic mclk,
    input wire logic step,
    input wire logic dir_up,
    input wire logic idx_en,
    output logic enc_a,
    output logic enc_b,
    output logic idx_in,
    output logic ready
);
    logic [1:0] ph = 2'h0; // phase, 0 is the all-low state
    logic [3:0] hold = 4'h0; // dwell counter of the present state
    // going up runs 00,10,11,01 so that a leads b
    assign enc_a = ph[0] ^ ph[1];
    assign enc_b = ph[1];
    // index low only inside the all-low state, like a real once-per-turn mark
    assign idx_in = !(idx_en && ph == 2'h0);
    assign ready = (hold == 4'h0);
    // ten clocks per state: one spare over the minimum guards against edge skew
    always @(posedge mclk) begin
        if (hold != 4'h0) begin
            hold <= hold - 4'h1;
        end else if (step) begin
            ph <= dir_up ? ph + 2'h1 : ph - 2'h1;
            hold <= 4'h9;
        end
    end
endmodule
